// ---- bench/liu_model.sv ----
`timescale 1ns/100ps
module liu_model (
    // from bench
    input  wire logic       active,
    input  wire logic [1:0] mode,
    input  wire logic       loss_req,
    // line pins
    output logic            line_clk,
    output logic            pos,
    output logic            neg,
    output logic            loss_out
);
    int   n;
    logic mark;
    logic zero;
    initial begin
        line_clk = 1'b0;
        pos = 1'b1;
        neg = 1'b0;
        n = 0;
        mark = 1'b0;
    end
    // odd half period keeps the line clock off the bus clock phase
    always #103 line_clk = active ? ~line_clk : 1'b0;
    // change on the falling edge so the rising edge sees settled rails
    always @(negedge line_clk) begin
        n = n + 1;
        mark = ~mark;
        case (mode)
            2'd1: zero = 1'b1;
            2'd2: zero = (n % 4) != 0;
            2'd3: zero = (n % 5) != 0;
            default: zero = 1'b0;
        endcase
        pos <= !zero && mark;
        neg <= !zero && !mark;
    end
    assign loss_out = loss_req;
endmodule : liu_model

// ---- bench/rx_e3_los_interrupt_logic_test.sv ----
`timescale 1ns/100ps
module rx_e3_los_interrupt_logic_test;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [4:0] lv;
        logic [7:0] exp;
    } row_s;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic [4:0]  lv      = 5'h00;
    logic        tx_p    = 1'b0;
    logic        sec_p   = 1'b0;
    logic        act     = 1'b0;
    logic [1:0]  mode    = 2'd0;
    logic        los_req = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, lclk, pos, neg, los_pin;
    wire         loss, ile, irq_n, fls;
    int          err_total = 0;
    int          checked = 0;
    logic [31:0] d;
    logic        e;
    row_s        rows [8] = '{
        '{rx_irq_pkg::IDX_RX_CFG, 8'h00, 5'h0D, 8'h68},
        '{rx_irq_pkg::IDX_RX_CFG, 8'hFF, 5'h02, 8'h81},
        '{rx_irq_pkg::IDX_RX_CFG, 8'h80, 5'h00, 8'h80},
        '{rx_irq_pkg::IDX_BLK_EN, 8'hFF, 5'h00, 8'h83},
        '{rx_irq_pkg::IDX_BLK_EN, 8'h00, 5'h00, 8'h00},
        '{rx_irq_pkg::IDX_SRC_EN, 8'hFF, 5'h00, 8'h1F},
        '{rx_irq_pkg::IDX_SRC_EN, 8'h00, 5'h00, 8'h00},
        '{rx_irq_pkg::IDX_SRC_STAT, 8'hFF, 5'h00, 8'h00}};
    // blk, src, expected status, expected request level
    logic [31:0] cmb [3] = '{32'h80020200, 32'h00020201, 32'h80000001};
    always #12.5 pclk = ~pclk;
    rx_e3_los_interrupt_logic dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line_clk(lclk), .rx_positive_rail(pos), .rx_negative_rail(neg),
        .line_loss_indication_in(los_pin), .rx_out_of_frame_state(lv[3]),
        .rx_frame_loss_state(lv[2]), .rx_alarm_indication_state(lv[0]),
        .rx_far_end_failure_state(lv[1]), .frame_alignment_change(lv[4]),
        .febe_event(1'b0), .bip4_error(1'b0), .framing_error(1'b0),
        .lapd_message_rx(1'b0), .tx_section_irq_pending(tx_p),
        .one_second_irq_pending(sec_p), .rx_signal_loss_state(loss),
        .internal_loss_detect_enable(ile), .frame_loss_algorithm_select(fls),
        .irq_n(irq_n));
    liu_model liu_u (.active(act), .mode(mode), .loss_req(los_req),
        .line_clk(lclk), .pos(pos), .neg(neg), .loss_out(los_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, logic [7:0] i, logic [7:0] v);
        @(posedge pclk);
        paddr <= {i[5:0], 2'b00};
        psel <= 1'b1;
        pwrite <= w;
        pwdata <= {24'h000000, v};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
        apb(1'b0, i, 8'h00);
        chk(d, {24'h000000, exp});
    endtask : rchk
    // bounded wait; the line side is slow and asynchronous
    task automatic wait_loss(input logic v);
        int n;
        n = 0;
        while (loss !== v && n < 600) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, loss}, {31'h0, v});
    endtask : wait_loss
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, irq_n}, 32'h1);
        rchk(rx_irq_pkg::IDX_SRC_STAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lv <= rows[i].lv;
            repeat (3) @(posedge pclk);
            apb(1'b1, rows[i].idx, rows[i].wd);
            rchk(rows[i].idx, rows[i].exp);
        end
        chk({31'h0, fls}, 32'h1);
        apb(1'b0, 8'h3F, 8'h00);
        chk({e, d[30:0]}, 32'h80000000);
        pstrb <= 4'h0;
        apb(1'b1, rx_irq_pkg::IDX_SRC_EN, 8'hFF);
        pstrb <= 4'hF;
        rchk(rx_irq_pkg::IDX_SRC_EN, 8'h00);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, rx_irq_pkg::IDX_BLK_EN, cmb[k][31:24]);
            apb(1'b1, rx_irq_pkg::IDX_SRC_EN, cmb[k][23:16]);
            apb(1'b0, rx_irq_pkg::IDX_SRC_STAT, 8'h00);
            los_req <= 1'b1;
            wait_loss(1'b1);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq_n}, {31'h0, cmb[k][0]});
            rchk(rx_irq_pkg::IDX_RX_CFG, 8'h90);
            rchk(rx_irq_pkg::IDX_SRC_STAT, cmb[k][15:8]);
            repeat (2) @(posedge pclk);
            chk({31'h0, irq_n}, 32'h1);
            rchk(rx_irq_pkg::IDX_SRC_STAT, 8'h00);
            los_req <= 1'b0;
            wait_loss(1'b0);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq_n}, {31'h0, cmb[k][0]});
            rchk(rx_irq_pkg::IDX_SRC_STAT, cmb[k][15:8]);
        end
        apb(1'b1, rx_irq_pkg::IDX_BLK_EN, 8'h80);
        for (int k = 0; k < 5; k++) begin
            if (k != 1) begin
                apb(1'b1, rx_irq_pkg::IDX_SRC_EN, 8'h01 << k);
                lv[k] <= 1'b1;
                @(posedge pclk);
                lv[k] <= 1'b0;
                repeat (4) @(posedge pclk);
                rchk(rx_irq_pkg::IDX_SRC_STAT, 8'h01 << k);
            end
        end
        apb(1'b1, rx_irq_pkg::IDX_LINE_CFG, 8'h20);
        @(posedge pclk);
        chk({31'h0, ile}, 32'h1);
        act <= 1'b1;
        mode <= 2'd1;
        wait_loss(1'b1);
        mode <= 2'd3;
        repeat (700) @(posedge pclk);
        chk({31'h0, loss}, 32'h1);
        mode <= 2'd2;
        wait_loss(1'b0);
        act <= 1'b0;
        apb(1'b1, rx_irq_pkg::IDX_LINE_CFG, 8'h00);
        apb(1'b1, rx_irq_pkg::IDX_BLK_EN, 8'h03);
        tx_p <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_n}, 32'h0);
        tx_p <= 1'b0;
        sec_p <= 1'b1;
        apb(1'b1, rx_irq_pkg::IDX_BLK_EN, 8'h02);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_n}, 32'h1);
        sec_p <= 1'b0;
        report_and_stop();
    end
endmodule : rx_e3_los_interrupt_logic_test

// ---- bench/rx_irq_chk.sv ----
`timescale 1ns/100ps
module rx_irq_chk #(
    parameter int SYNC_DEPTH = rx_irq_pkg::SYNC_STAGES
) (
    // clock, reset, apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // line and interrupt
    input  wire logic        line_loss_indication_in,
    input  wire logic        tx_section_irq_pending,
    input  wire logic        one_second_irq_pending,
    input  wire logic        rx_signal_loss_state,
    input  wire logic        internal_loss_detect_enable,
    input  wire logic        irq_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] idx;
    logic       acc;
    logic       rd;
    logic       wr_ok;
    logic       touch;
    logic       quiet;
    logic [2:0] blk_q;
    logic       src_q;
    ////////////////////////////////////////////////////////////////////////
    assign idx   = {2'b00, paddr[7:2]};
    assign acc   = psel && penable && pready;
    assign rd    = acc && !pwrite;
    assign wr_ok = acc && pwrite && pstrb[0];
    // any access that may legally release the request line
    assign touch = acc && (idx == rx_irq_pkg::IDX_BLK_EN
        || idx == rx_irq_pkg::IDX_SRC_EN || idx == rx_irq_pkg::IDX_AUX_EN
        || idx == rx_irq_pkg::IDX_SRC_STAT || idx == rx_irq_pkg::IDX_AUX_STAT);
    assign quiet = !touch && !tx_section_irq_pending
        && !one_second_irq_pending;
    // shadow of the enables, seen from the bus only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_q <= 3'h0;
            src_q <= 1'b0;
        end else if (wr_ok && idx == rx_irq_pkg::IDX_BLK_EN) begin
            blk_q <= {pwdata[7], pwdata[1:0]};
        end else if (wr_ok && idx == rx_irq_pkg::IDX_SRC_EN) begin
            src_q <= pwdata[1];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ext_set;
        $rose(line_loss_indication_in) |-> ##[1:8] rx_signal_loss_state;
    endproperty
    a_ext_set: assert property (p_ext_set)
        else $error("loss not declared");
    property p_ext_clr;
        $fell(line_loss_indication_in) && !internal_loss_detect_enable
            |-> ##[1:8] !rx_signal_loss_state;
    endproperty
    a_ext_clr: assert property (p_ext_clr)
        else $error("loss not cleared");
    property p_int_off;
        (!line_loss_indication_in && !internal_loss_detect_enable)[*8]
            |-> !rx_signal_loss_state;
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("loss without cause");
    property p_irq_cause;
        $fell(irq_n) |-> $past(blk_q) != 3'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request with block disabled");
    property p_los_irq;
        $changed(rx_signal_loss_state) && src_q && blk_q[2]
            |-> ##[1:3] !irq_n;
    endproperty
    a_los_irq: assert property (p_los_irq)
        else $error("loss change gave no request");
    property p_irq_hold;
        !irq_n && quiet && $past(quiet) |=> !irq_n;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("request dropped early");
    property p_blk_rsvd;
        rd && idx == rx_irq_pkg::IDX_BLK_EN |-> prdata[6:2] == 5'h00;
    endproperty
    a_blk_rsvd: assert property (p_blk_rsvd)
        else $error("unused block bits not zero");
    property p_src_rsvd;
        rd && (idx == rx_irq_pkg::IDX_SRC_EN
            || idx == rx_irq_pkg::IDX_SRC_STAT) |-> prdata[7:5] == 3'h0;
    endproperty
    a_src_rsvd: assert property (p_src_rsvd)
        else $error("unused source bits not zero");
    property p_cfg_live;
        rd && idx == rx_irq_pkg::IDX_RX_CFG |->
            prdata[rx_irq_pkg::BIT_LIVE_LOS] == $past(rx_signal_loss_state);
    endproperty
    a_cfg_live: assert property (p_cfg_live)
        else $error("live loss bit wrong");
    property p_rx_gate;
        (!blk_q[2] && !tx_section_irq_pending && !one_second_irq_pending)[*3]
            |-> irq_n;
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("request with receive block off");
    c_irq: cover property ($fell(irq_n));
    c_int: cover property (internal_loss_detect_enable
        && $rose(rx_signal_loss_state));
    c_err: cover property (acc && pslverr);
endmodule : rx_irq_chk
bind rx_e3_los_interrupt_logic rx_irq_chk #(.SYNC_DEPTH(SYNC_DEPTH)) chk_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .line_loss_indication_in,
    .tx_section_irq_pending, .one_second_irq_pending, .rx_signal_loss_state,
    .internal_loss_detect_enable, .irq_n);

// ---- hw/los_zero_run_detector.sv ----
`timescale 1ns/100ps
module los_zero_run_detector #(
    parameter int RUN_LEN    = rx_irq_pkg::LOS_DECLARE_ZEROS,
    parameter int WINDOW_LEN = rx_irq_pkg::LOS_CLEAR_BITS,
    parameter int ZERO_LIMIT = rx_irq_pkg::LOS_ZERO_LIMIT
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // line bits
    input  wire logic enable,
    input  wire logic bit_valid,
    input  wire logic bit_zero,
    // state
    output logic      loss
);

    localparam int CW = $clog2((RUN_LEN > WINDOW_LEN ? RUN_LEN : WINDOW_LEN)
                               + 1);
    localparam logic [CW-1:0] RUN_MAX = CW'(RUN_LEN);
    localparam logic [CW-1:0] WIN_MAX = CW'(WINDOW_LEN);
    localparam logic [CW-1:0] ZLIM    = CW'(ZERO_LIMIT);
    localparam logic [CW-1:0] ONE     = CW'(1);

    logic [CW-1:0] zrun_q;
    logic [CW-1:0] zrun_d;
    logic [CW-1:0] win_q;
    logic [CW-1:0] win_d;
    logic          loss_q;
    logic          loss_d;
    logic          long_zero;

    ////////////////////////////////////////////////////////////////////////
    // counters saturate so a dead line never wraps back to clear
    assign zrun_d    = !bit_zero ? '0
                     : (zrun_q == RUN_MAX) ? zrun_q : zrun_q + ONE;
    assign long_zero = bit_zero && (zrun_d >= ZLIM);
    assign win_d     = long_zero ? '0
                     : (win_q == WIN_MAX) ? win_q : win_q + ONE;
    assign loss_d    = !loss_q ? (zrun_d == RUN_MAX)       // [R07]
                     : !(win_d == WIN_MAX);                // [R09]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zrun_q <= '0;
            win_q  <= '0;
            loss_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable) begin
                zrun_q <= '0;
                win_q  <= '0;
                loss_q <= 1'b0;
            end else if (bit_valid) begin
                zrun_q <= zrun_d;
                win_q  <= win_d;
                loss_q <= loss_d;
            end
        end
    end

    assign loss = loss_q;

endmodule : los_zero_run_detector

// ---- hw/rx_e3_los_interrupt_logic.sv ----
`timescale 1ns/100ps
module rx_e3_los_interrupt_logic #(
    parameter int SYNC_DEPTH = rx_irq_pkg::SYNC_STAGES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // line interface pins
    input  wire logic        rx_line_clk,
    input  wire logic        rx_positive_rail,
    input  wire logic        rx_negative_rail,
    input  wire logic        line_loss_indication_in,
    // framer states and events
    input  wire logic        rx_out_of_frame_state,
    input  wire logic        rx_frame_loss_state,
    input  wire logic        rx_alarm_indication_state,
    input  wire logic        rx_far_end_failure_state,
    input  wire logic        frame_alignment_change,
    input  wire logic        febe_event,
    input  wire logic        bip4_error,
    input  wire logic        framing_error,
    input  wire logic        lapd_message_rx,
    // other sections
    input  wire logic        tx_section_irq_pending,
    input  wire logic        one_second_irq_pending,
    // outputs
    output logic             rx_signal_loss_state,
    output logic             internal_loss_detect_enable,
    output logic             frame_loss_algorithm_select,
    output logic             irq_n
);

    localparam int NS = rx_irq_pkg::NUM_SRC;
    localparam int NE = rx_irq_pkg::NUM_EVT;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: clk, pos, neg, loss indication

    localparam int NPIN = 4;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_filt_q;
    logic [NPIN-1:0] pin_filt_d;
    logic            line_clk_prev_q;

    assign pin_raw = {line_loss_indication_in, rx_negative_rail,
                      rx_positive_rail, rx_line_clk};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_pin
            logic [SYNC_DEPTH-1:0] sh_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sh_q <= '0;
                end else if (clk_en) begin
                    sh_q <= {sh_q[SYNC_DEPTH-2:0], pin_raw[gp]};
                end
            end
            // only the two later stages are compared
            assign pin_filt_d[gp] =
                (sh_q[SYNC_DEPTH-1] == sh_q[SYNC_DEPTH-2])
                ? sh_q[SYNC_DEPTH-1] : pin_filt_q[gp];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_filt_q      <= '0;
            line_clk_prev_q <= 1'b0;
        end else if (clk_en) begin
            pin_filt_q      <= pin_filt_d;
            line_clk_prev_q <= pin_filt_q[0];
        end
    end

    wire line_bit_valid = pin_filt_q[0] && !line_clk_prev_q;
    wire line_bit_zero  = !pin_filt_q[1] && !pin_filt_q[2];
    wire ext_loss       = pin_filt_q[3];

    ////////////////////////////////////////////////////////////////////////
    // loss of signal state

    logic int_los_en_q;
    logic int_loss;
    logic los_q;

    los_zero_run_detector #(
        .RUN_LEN    (rx_irq_pkg::LOS_DECLARE_ZEROS),
        .WINDOW_LEN (rx_irq_pkg::LOS_CLEAR_BITS),
        .ZERO_LIMIT (rx_irq_pkg::LOS_ZERO_LIMIT)
    ) u_zero_run (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .enable    (int_los_en_q),
        .bit_valid (line_bit_valid),
        .bit_zero  (line_bit_zero),
        .loss      (int_loss)
    );

    // either source holds the state; each clears only its own part
    wire los_d = ext_loss || int_loss;                // [R06] [R08]

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic [7:0] blk_en_q;
    logic       algo_q;
    logic [4:0] src_en_q;
    logic [4:0] aux_en_q;
    logic [NE-1:0] stat_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    wire [7:0] idx      = {2'b00, paddr[7:2]};
    wire       setup    = psel && !penable;
    wire       access   = psel && penable && clk_en;
    wire       wr_ok    = access && pwrite && pstrb[0];
    wire       rd_done  = access && !pwrite;

    wire hit_line = idx == rx_irq_pkg::IDX_LINE_CFG;
    wire hit_blk  = idx == rx_irq_pkg::IDX_BLK_EN;
    wire hit_cfg  = idx == rx_irq_pkg::IDX_RX_CFG;
    wire hit_sen  = idx == rx_irq_pkg::IDX_SRC_EN;
    wire hit_aen  = idx == rx_irq_pkg::IDX_AUX_EN;
    wire hit_sst  = idx == rx_irq_pkg::IDX_SRC_STAT;
    wire hit_ast  = idx == rx_irq_pkg::IDX_AUX_STAT;
    wire mapped   = hit_line || hit_blk || hit_cfg || hit_sen
                    || hit_aen || hit_sst || hit_ast;
    wire [1:0] amisc = paddr[1:0];
    wire bad_addr = !mapped || (amisc != 2'b00);

    // live state view
    logic [7:0] cfg_view;
    always_comb begin
        cfg_view = 8'h00;
        cfg_view[rx_irq_pkg::BIT_ALGO]      = algo_q;             // [R16]
        cfg_view[rx_irq_pkg::BIT_LIVE_LOF]  = rx_frame_loss_state;
        cfg_view[rx_irq_pkg::BIT_LIVE_OOF]  = rx_out_of_frame_state;
        cfg_view[rx_irq_pkg::BIT_LIVE_LOS]  = los_q;              // [R15]
        cfg_view[rx_irq_pkg::BIT_LIVE_AIS]  = rx_alarm_indication_state;
        cfg_view[rx_irq_pkg::BIT_LIVE_FERF] = rx_far_end_failure_state;
    end

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_line) begin
            rd_byte[rx_irq_pkg::BIT_INT_LOS] = int_los_en_q;
        end
        if (hit_blk) begin
            rd_byte = blk_en_q;                                   // [R04]
        end
        if (hit_cfg) begin
            rd_byte = cfg_view;
        end
        if (hit_sen) begin
            rd_byte = {3'b000, src_en_q};                         // [R11]
        end
        if (hit_aen) begin
            rd_byte = {3'b000, aux_en_q};
        end
        if (hit_sst) begin
            rd_byte = {3'b000, stat_q[NS-1:0]};                   // [R14]
        end
        if (hit_ast) begin
            rd_byte = {3'b000, stat_q[NE-1:NS]};
        end
    end

    // read data latched in setup so the access phase shows a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (clk_en && setup) begin
            prdata_q  <= {24'h00_0000, rd_byte};
            pslverr_q <= bad_addr;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;
    // a frozen block stretches the access instead of losing it
    assign pready  = clk_en;

    ////////////////////////////////////////////////////////////////////////
    // writable registers

    wire [7:0] wbyte   = pwdata[7:0];
    wire [7:0] blk_msk = 8'h00 | (8'h01 << rx_irq_pkg::BIT_BLK_RX)
                         | (8'h01 << rx_irq_pkg::BIT_BLK_TX)
                         | (8'h01 << rx_irq_pkg::BIT_BLK_SEC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_en_q     <= rx_irq_pkg::RST_BYTE;
            algo_q       <= 1'b0;
            src_en_q     <= 5'h00;
            aux_en_q     <= 5'h00;
            int_los_en_q <= 1'b0;
        end else if (wr_ok && !bad_addr) begin
            if (hit_blk) begin
                blk_en_q <= wbyte & blk_msk;                // [R03] [R04]
            end
            if (hit_cfg) begin
                algo_q <= wbyte[rx_irq_pkg::BIT_ALGO];
            end
            if (hit_sen) begin
                src_en_q <= wbyte[4:0];                     // [R10] [R11]
            end
            if (hit_aen) begin
                aux_en_q <= wbyte[4:0];
            end
            if (hit_line) begin
                int_los_en_q <= wbyte[rx_irq_pkg::BIT_INT_LOS];   // [R07]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state change detection

    logic [4:0] lvl_prev_q;
    wire  [4:0] lvl_now = {rx_far_end_failure_state, rx_out_of_frame_state,
                           rx_frame_loss_state, los_q,
                           rx_alarm_indication_state};
    wire  [4:0] lvl_chg = lvl_now ^ lvl_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_q      <= 1'b0;
            lvl_prev_q <= 5'h00;
        end else if (clk_en) begin
            los_q      <= los_d;
            lvl_prev_q <= lvl_now;
        end
    end

    // both edges of each state count as an event
    wire [NE-1:0] evt = {lapd_message_rx, framing_error, bip4_error,
                         febe_event, lvl_chg[4],
                         frame_alignment_change, lvl_chg[3],
                         lvl_chg[2], lvl_chg[1], lvl_chg[0]};  // [R01] [R05]
    wire [NE-1:0] en_all = {aux_en_q, src_en_q};
    wire [NE-1:0] clr    = {{NS{rd_done && hit_ast}},
                            {NS{rd_done && hit_sst}}};

    ////////////////////////////////////////////////////////////////////////
    // sticky status, cleared by read; a new event beats the clear

    genvar ge;
    generate
        for (ge = 0; ge < NE; ge++) begin : g_stat
            wire set_i = evt[ge] && en_all[ge];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stat_q[ge] <= 1'b0;
                end else if (clk_en) begin
                    stat_q[ge] <= set_i || (stat_q[ge] && !clr[ge]); // [R13]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt output, registered to keep the pin glitch free

    logic irq_n_q;
    wire  rx_pend  = |(stat_q & en_all);
    wire  rx_req   = blk_en_q[rx_irq_pkg::BIT_BLK_RX] && rx_pend;  // [R02]
    wire  tx_req   = blk_en_q[rx_irq_pkg::BIT_BLK_TX]
                     && tx_section_irq_pending;
    wire  sec_req  = blk_en_q[rx_irq_pkg::BIT_BLK_SEC]
                     && one_second_irq_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_q <= rx_irq_pkg::RST_IRQ_N;
        end else if (clk_en) begin
            irq_n_q <= !(rx_req || tx_req || sec_req);      // [R12] [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign irq_n                       = irq_n_q;
    assign rx_signal_loss_state        = los_q;
    assign internal_loss_detect_enable = int_los_en_q;
    assign frame_loss_algorithm_select = algo_q;

endmodule : rx_e3_los_interrupt_logic

// ---- hw/rx_irq_pkg.sv ----
// Operation
// [R01] receive section raises ten kinds of interrupt
// [R02] source interrupt needs block enable too
// [R03] block enable bit 7 gates receive interrupts
// [R04] bits 1,0 read-write; bits 6..2 read zero
// [R05] loss change fires on declare and clear
// [R06] external loss indication high declares loss
// [R07] internal detect: 32 zeros declares loss
// [R08] external loss indication low clears loss
// [R09] internal detect: 32 bits without 4-zero clears
// [R10] source enable bit 1 gates loss interrupt
// [R11] source enable register bits 4..0, 7..5 zero
// [R12] enabled loss change drives irq_n low
// [R13] loss change sets status bit 1; code sets it only while source enable bit 1 is set
// [R14] status bits 4..0 cleared by read
// [R15] host reads live loss at bit 4
// [R16] config register: algo bit 7, live states
// [R17] irq_n low while enabled status pending
package rx_irq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINE_CFG   = 8'h00;
    localparam logic [7:0] IDX_BLK_EN     = 8'h04;
    localparam logic [7:0] IDX_RX_CFG     = 8'h11;
    localparam logic [7:0] IDX_SRC_EN     = 8'h12;
    localparam logic [7:0] IDX_AUX_EN     = 8'h13;
    localparam logic [7:0] IDX_SRC_STAT   = 8'h14;
    localparam logic [7:0] IDX_AUX_STAT   = 8'h15;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_INT_LOS    = 5;
    localparam int BIT_BLK_RX     = 7;
    localparam int BIT_BLK_TX     = 1;
    localparam int BIT_BLK_SEC    = 0;
    localparam int BIT_ALGO       = 7;
    localparam int BIT_LIVE_LOF   = 6;
    localparam int BIT_LIVE_OOF   = 5;
    localparam int BIT_LIVE_LOS   = 4;
    localparam int BIT_LIVE_AIS   = 3;
    localparam int BIT_LIVE_FERF  = 0;
    localparam int NUM_SRC        = 5;
    localparam int NUM_EVT        = 10;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic       RST_IRQ_N      = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // loss detection counts, in line bits; synchroniser depth, in pclk stages
    localparam int LOS_DECLARE_ZEROS = 32;
    localparam int LOS_CLEAR_BITS    = 32;
    localparam int LOS_ZERO_LIMIT    = 4;
    localparam int SYNC_STAGES       = 3;

endpackage : rx_irq_pkg
